/* File: src/sar_fabric_pkg.sv */
// Constants and types shared by the fabric-control sequencer
package sar_fabric_pkg;
	// Channel count and bus geometry
	localparam int NCH = 4;
	localparam int AW = 8;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STIME = 8'h04;
	localparam logic [7:0] OFS_CHEN = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_WORK0 = 8'h10;
	localparam logic [7:0] OFS_CFG0 = 8'h20;
	localparam logic [7:0] OFS_RES0 = 8'h40;
	// Control register fields
	localparam int CTRL_FAB_BIT = 0;
	localparam int CTRL_SYNC_BIT = 1;
	localparam int CTRL_CONT_BIT = 2;
	localparam int CTRL_FTRIG_BIT = 3;
	localparam int CTRL_SUB10_BIT = 4;
	localparam int CTRL_FW_BIT = 8;
	// Channel configuration fields
	localparam int CFG_OUT_BIT = 31;
	localparam int CFG_DIFF_BIT = 8;
	localparam int CFG_RES_BIT = 9;
	localparam int CFG_AVG_BIT = 10;
	localparam int CFG_ST_LSB = 12;
	localparam logic [31:0] CFG_MASK = 32'h80003700;
	// Status register fields
	localparam int ST_SAT_LSB = 0;
	localparam int ST_RNG_LSB = 4;
	localparam int ST_EOS_BIT = 8;
	// Reset values
	localparam logic [4:0] CTRL_RST = 5'h00;
	localparam logic [31:0] STIME_RST = 32'h03030303;
	localparam logic [3:0] CHEN_RST = 4'h0;
	// Resolution codes in bits
	localparam logic [3:0] RES_12 = 4'hc;
	localparam logic [3:0] RES_10 = 4'ha;
	localparam logic [3:0] RES_8 = 4'h8;
	// Fabric output hold time in clock cycles
	localparam logic [1:0] HOLD_CYC = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SAMPLE = 3'b010,
		ST_CONVERT = 3'b100
	} seq_state_t;

	typedef struct packed {
		logic trig;
		logic [1:0] st_sel;
		logic average;
		logic resolution;
		logic differential;
	} fab_cfg_t;

	typedef struct packed {
		logic [1:0] channel;
		logic [7:0] sample_time;
		logic [3:0] bits;
		logic average;
		logic differential;
	} conv_cmd_t;

	typedef struct packed {
		logic next;
		logic done;
		logic [15:0] result;
		logic saturate;
		logic range_hit;
	} adc_resp_t;

	typedef struct packed {
		logic read;
		logic write;
		logic [AW-1:0] address;
		logic [31:0] writedata;
	} av_req_t;

	typedef struct packed {
		logic waitrequest;
		logic [31:0] readdata;
	} av_rsp_t;

	typedef struct packed {
		logic sample_done;
		logic tag_valid;
		logic [3:0] tag;
		logic data_valid;
		logic eos;
	} fab_out_t;
endpackage

/* File: src/sar_fabric_control_port.sv */
// Conversion sequencer with fabric-control mode and register bus
//
// Local design decisions: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module sar_fabric_control_port
	import sar_fabric_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire av_req_t av_req,
	output av_rsp_t av_rsp,
	input wire fab_cfg_t fab_cfg_in,
	input wire logic hilo_sel,
	output fab_out_t fab_out,
	output logic [11:0] fab_data,
	input wire adc_resp_t adc_resp,
	output conv_cmd_t conv_cmd,
	output logic conv_start,
	output logic [NCH-1:0] switch_en
);

	typedef struct packed {
		seq_state_t state;
		logic [4:0] ctrl;
		logic [31:0] stime;
		logic [NCH-1:0] chen;
		logic [NCH-1:0][31:0] cfg;
		logic [NCH-1:0] sat_st;
		logic [NCH-1:0] rng_st;
		logic eos_st;
		logic [15:0] work0;
		logic [NCH-1:0][15:0] result;
		logic fw_pend;
		logic [1:0] cur_ch;
		logic cur_out;
		fab_cfg_t s1;
		fab_cfg_t s2;
		fab_cfg_t s3;
		fab_cfg_t acc;
		logic trig_prev;
		logic wreq;
		logic [31:0] rdata;
		conv_cmd_t cmd;
		logic start;
		logic [NCH-1:0] sw_en;
		fab_out_t fo;
		logic [1:0] tag_cnt;
		logic [1:0] data_cnt;
		logic [15:0] dout;
		logic pend;
		logic pend_last;
		logic pend_out;
		logic [1:0] pend_flags;
		logic [1:0] pend_ch;
	} regs_t;

	regs_t r_reg;
	regs_t r_next;

	// Lowest enabled channel at or above a start index
	function automatic logic [2:0] next_ch(
		input logic [NCH-1:0] en,
		input logic [2:0] from
	);
		logic [2:0] res;
		res = 3'b000;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (en[i] && 3'(i) >= from) begin
				res = {1'b1, 2'(i)};
			end
		end
		return res;
	endfunction

	// Hit and index inside a block of per-channel words
	function automatic logic [2:0] region(
		input logic [AW-1:0] addr,
		input logic [AW-1:0] base
	);
		logic [AW-1:0] off;
		off = addr - base;
		region = {(off[1:0] == 2'h0) && (off[AW-1:4] == '0), off[3:2]};
	endfunction

	// Command for the converter core from one set of settings
	function automatic conv_cmd_t make_cmd(
		input logic [1:0] ch,
		input logic [1:0] st_sel,
		input logic res_alt,
		input logic avg,
		input logic diff,
		input logic [31:0] stime,
		input logic sub10
	);
		conv_cmd_t c;
		c.channel = ch;
		c.sample_time = stime[8*st_sel +: 8];
		if (!res_alt) begin
			c.bits = RES_12;
		end else if (sub10) begin
			c.bits = RES_10;
		end else begin
			c.bits = RES_8;
		end
		c.average = avg;
		c.differential = diff;
		return c;
	endfunction

	// Working signals of the next-state process
	fab_cfg_t sel;
	logic fab_mode;
	logic go;
	logic trig_fab;
	logic [2:0] nc;
	logic [2:0] ci;
	logic [2:0] ri;
	logic [31:0] rd;
	logic [31:0] wd;
	logic [NCH-1:0] sat_clr;
	logic [NCH-1:0] rng_clr;
	logic eos_clr;
	logic [NCH-1:0] sat_set;
	logic [NCH-1:0] rng_set;
	logic eos_set;
	logic fw_set;
	logic fw_take;
	logic [31:0] chcfg;

	// Whole next state in one place
	always_comb begin
		r_next = r_reg;
		fab_mode = r_reg.ctrl[CTRL_FAB_BIT];
		wd = av_req.writedata;
		sat_clr = '0;
		rng_clr = '0;
		eos_clr = 1'b0;
		sat_set = '0;
		rng_set = '0;
		eos_set = 1'b0;
		fw_set = 1'b0;
		fw_take = 1'b0;
		nc = 3'b000;
		chcfg = r_reg.cfg[r_reg.cur_ch];
		ci = region(av_req.address, OFS_CFG0);
		ri = region(av_req.address, OFS_RES0);
		rd = 32'h0;

		// Three stages; a change counts once the last two agree
		r_next.s1 = fab_cfg_in;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		r_next.acc = (r_reg.s2 & r_reg.s3) | (r_reg.acc & (r_reg.s2 ^ r_reg.s3));
		// Bypass helps slow converter clocks at the cost of metastability margin
		sel = r_reg.ctrl[CTRL_SYNC_BIT] ? r_reg.acc : fab_cfg_in;

		// Rising edge of the fabric trigger, only when that source is enabled
		trig_fab = r_reg.ctrl[CTRL_FTRIG_BIT] && sel.trig && !r_reg.trig_prev;
		r_next.trig_prev = sel.trig;
		go = r_reg.fw_pend || trig_fab || r_reg.ctrl[CTRL_CONT_BIT];

		// Register read data, prepared one cycle ahead of the answer
		if (av_req.address == OFS_CTRL) begin
			rd = {27'h0, r_reg.ctrl};
		end else if (av_req.address == OFS_STIME) begin
			rd = r_reg.stime;
		end else if (av_req.address == OFS_CHEN) begin
			rd = {28'h0, r_reg.chen};
		end else if (av_req.address == OFS_STATUS) begin
			rd = {15'h0, r_reg.state != ST_IDLE, 7'h0, r_reg.eos_st, r_reg.rng_st, r_reg.sat_st};
		end else if (av_req.address == OFS_WORK0) begin
			rd = {16'h0, r_reg.work0};
		end else if (ci[2]) begin
			rd = r_reg.cfg[ci[1:0]];
		end else if (ri[2]) begin
			rd = {16'h0, r_reg.result[ri[1:0]]};
		end else begin
			rd = 32'h0;
		end

		// Bus slave: one wait cycle, then the request is taken
		r_next.wreq = 1'b1;
		if ((av_req.read || av_req.write) && r_reg.wreq) begin
			r_next.wreq = 1'b0;
			r_next.rdata = av_req.read ? rd : 32'h0;
		end else if (av_req.write && !r_reg.wreq) begin
			if (av_req.address == OFS_CTRL) begin
				r_next.ctrl = wd[4:0];
				fw_set = wd[CTRL_FW_BIT];
			end else if (av_req.address == OFS_STIME) begin
				r_next.stime = wd;
			end else if (av_req.address == OFS_CHEN) begin
				r_next.chen = wd[NCH-1:0];
			end else if (av_req.address == OFS_STATUS) begin
				sat_clr = wd[ST_SAT_LSB +: NCH];
				rng_clr = wd[ST_RNG_LSB +: NCH];
				eos_clr = wd[ST_EOS_BIT];
			end else if (ci[2]) begin
				r_next.cfg[ci[1:0]] = wd & CFG_MASK;
			end
		end

		// Converter command and sample-done follow the core
		r_next.start = 1'b0;
		r_next.fo.sample_done = adc_resp.next;

		// Scan sequencer
		case (r_reg.state)
			ST_IDLE: begin
				if (go) begin
					fw_take = 1'b1;
					if (fab_mode) begin
						// Settings latched here; fabric keeps them until sample-done
						r_next.cmd = make_cmd(2'h0, sel.st_sel, sel.resolution, sel.average,
							sel.differential, r_reg.stime, r_reg.ctrl[CTRL_SUB10_BIT]);
						r_next.cur_ch = 2'h0;
						r_next.cur_out = 1'b1;
						r_next.sw_en = '0;
						r_next.start = 1'b1;
						r_next.state = ST_SAMPLE;
					end else begin
						nc = next_ch(r_reg.chen, 3'h0);
						if (nc[2]) begin
							chcfg = r_reg.cfg[nc[1:0]];
							r_next.cmd = make_cmd(nc[1:0], chcfg[CFG_ST_LSB +: 2], chcfg[CFG_RES_BIT],
								chcfg[CFG_AVG_BIT], chcfg[CFG_DIFF_BIT], r_reg.stime,
								r_reg.ctrl[CTRL_SUB10_BIT]);
							r_next.cur_ch = nc[1:0];
							r_next.cur_out = chcfg[CFG_OUT_BIT];
							r_next.sw_en = NCH'(1) << nc[1:0];
							r_next.start = 1'b1;
							r_next.state = ST_SAMPLE;
						end
					end
				end
			end
			ST_SAMPLE: begin
				if (adc_resp.next) begin
					// Early channel tag, so the fabric can prepare the next input
					if (r_reg.cur_out) begin
						r_next.fo.tag = {2'h0, r_reg.cur_ch};
						r_next.fo.tag_valid = 1'b1;
						r_next.tag_cnt = HOLD_CYC;
					end
					r_next.sw_en = '0;
					r_next.state = ST_CONVERT;
				end
			end
			ST_CONVERT: begin
				if (adc_resp.done) begin
					if (r_reg.cur_ch == 2'h0) begin
						r_next.work0 = adc_resp.result;
					end
					r_next.result[r_reg.cur_ch] = adc_resp.result;
					sat_set[r_reg.cur_ch] = adc_resp.saturate;
					rng_set[r_reg.cur_ch] = adc_resp.range_hit;
					r_next.pend = 1'b1;
					r_next.pend_out = r_reg.cur_out;
					// Scan may already have moved on to the next channel
					r_next.pend_ch = r_reg.cur_ch;
					r_next.pend_flags = {adc_resp.range_hit, adc_resp.saturate};
					if (fab_mode) begin
						r_next.pend_last = 1'b1;
						r_next.state = ST_IDLE;
					end else begin
						nc = next_ch(r_reg.chen, {1'b0, r_reg.cur_ch} + 3'h1);
						r_next.pend_last = !nc[2];
						if (nc[2]) begin
							chcfg = r_reg.cfg[nc[1:0]];
							r_next.cmd = make_cmd(nc[1:0], chcfg[CFG_ST_LSB +: 2], chcfg[CFG_RES_BIT],
								chcfg[CFG_AVG_BIT], chcfg[CFG_DIFF_BIT], r_reg.stime,
								r_reg.ctrl[CTRL_SUB10_BIT]);
							r_next.cur_ch = nc[1:0];
							r_next.cur_out = chcfg[CFG_OUT_BIT];
							r_next.sw_en = NCH'(1) << nc[1:0];
							r_next.start = 1'b1;
							r_next.state = ST_SAMPLE;
						end else begin
							r_next.state = ST_IDLE;
						end
					end
				end
			end
			default: begin
				r_next.state = ST_IDLE;
			end
		endcase

		// Hold counters for the fabric strobes
		if (r_reg.tag_cnt != 2'h0) begin
			r_next.tag_cnt = r_reg.tag_cnt - 2'h1;
			r_next.fo.tag_valid = (r_reg.tag_cnt == HOLD_CYC);
		end
		if (r_reg.data_cnt != 2'h0) begin
			r_next.data_cnt = r_reg.data_cnt - 2'h1;
			r_next.fo.data_valid = (r_reg.data_cnt == HOLD_CYC) && r_reg.pend_out;
			r_next.fo.eos = (r_reg.data_cnt == HOLD_CYC) && r_reg.pend_last;
		end
		if (r_reg.state == ST_SAMPLE && adc_resp.next && r_reg.cur_out) begin
			r_next.fo.tag_valid = 1'b1;
		end

		// Result goes out two cycles after completion
		if (r_reg.pend) begin
			r_next.pend = 1'b0;
			r_next.data_cnt = HOLD_CYC;
			eos_set = r_reg.pend_last;
			r_next.fo.eos = r_reg.pend_last;
			r_next.fo.data_valid = r_reg.pend_out;
			if (r_reg.pend_out) begin
				r_next.dout = r_reg.result[r_reg.pend_ch];
				if (fab_mode) begin
					r_next.dout = r_reg.work0;
					r_next.fo.tag = {2'h0, r_reg.pend_flags};
					r_next.fo.tag_valid = 1'b1;
					r_next.tag_cnt = HOLD_CYC;
				end
			end
		end

		// Sticky status; a hardware set wins over a software clear
		r_next.sat_st = (r_reg.sat_st & ~sat_clr) | sat_set;
		r_next.rng_st = (r_reg.rng_st & ~rng_clr) | rng_set;
		r_next.eos_st = (r_reg.eos_st & ~eos_clr) | eos_set;
		r_next.fw_pend = (r_reg.fw_pend && !fw_take) || fw_set;
	end

	// State register; every field has a constant reset value
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r_reg <= '0;
			r_reg.state <= ST_IDLE;
			r_reg.ctrl <= CTRL_RST;
			r_reg.stime <= STIME_RST;
			r_reg.chen <= CHEN_RST;
			r_reg.wreq <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	// Outputs straight from the state register
	assign av_rsp.waitrequest = r_reg.wreq;
	assign av_rsp.readdata = r_reg.rdata;
	assign fab_out = r_reg.fo;
	assign conv_cmd = r_reg.cmd;
	assign conv_start = r_reg.start;
	assign switch_en = r_reg.sw_en;

	// Byte select is a pure mux so the fabric can flip it within one hold window;
	// the fabric itself joins the two overlapping parts
	assign fab_data = hilo_sel ? {4'h0, r_reg.dout[15:8]} : r_reg.dout[11:0];

endmodule

/* File: tb/sar_fabric_monitor.sv */
// Port checker for the fabric-control sequencer
`timescale 1ns/1ps
module sar_fabric_monitor
	import sar_fabric_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire av_req_t av_req,
	input wire av_rsp_t av_rsp,
	input wire fab_cfg_t fab_cfg_in,
	input wire logic hilo_sel,
	input wire fab_out_t fab_out,
	input wire logic [11:0] fab_data,
	input wire adc_resp_t adc_resp,
	input wire conv_cmd_t conv_cmd,
	input wire logic conv_start,
	input wire logic [NCH-1:0] switch_en
);
	logic fab_reg;
	logic fab_next;
	// Mode mirror taken where a control write lands, so no bus cycles are spent reading it back
	always_comb begin
		fab_next = fab_reg;
		if (av_req.write && !av_rsp.waitrequest && av_req.address == OFS_CTRL) begin
			fab_next = av_req.writedata[CTRL_FAB_BIT];
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fab_reg <= 1'b0;
		end else begin
			fab_reg <= fab_next;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	chan_zero_a: assert property (fab_reg && conv_start |-> conv_cmd.channel == 2'h0)
		else $error("channel not zero");
	flag_tag_a: assert property (fab_reg && $rose(fab_out.data_valid) |->
		fab_out.tag == {2'h0, $past(adc_resp.range_hit, 2), $past(adc_resp.saturate, 2)})
		else $error("flags not on tag");
	eos_copy_a: assert property (fab_reg |-> fab_out.eos == fab_out.data_valid)
		else $error("eos differs");
	hilo_high_a: assert property (hilo_sel |-> fab_data[11:8] == 4'h0)
		else $error("upper part not clear");
	early_tag_a: assert property (fab_reg && adc_resp.next |=> fab_out.tag_valid && fab_out.tag == 4'h0)
		else $error("early tag missing");
	data_delay_a: assert property (fab_reg && adc_resp.done |-> ##1 !fab_out.data_valid ##1 fab_out.data_valid)
		else $error("data timing");
	// Data and tag strobes are held separately; in both modes the tag first comes out at sample-done, ahead of the data
	hold_two_a: assert property ($rose(fab_out.data_valid) |=> fab_out.data_valid ##1 !fab_out.data_valid)
		else $error("hold not two cycles");
	tag_hold_a: assert property ($rose(fab_out.tag_valid) |=> fab_out.tag_valid && $stable(fab_out.tag) ##1 !fab_out.tag_valid)
		else $error("tag hold not two cycles");
	done_pulse_a: assert property (adc_resp.next |=> fab_out.sample_done ##1 !fab_out.sample_done)
		else $error("sample done pulse");
	no_switch_a: assert property (fab_reg |-> switch_en == '0)
		else $error("switch enable in fabric mode");
	cover property (fab_reg && $rose(fab_out.data_valid));
	cover property (hilo_sel && fab_out.data_valid);
	cover property (!fab_reg && conv_start);
endmodule
bind sar_fabric_control_port sar_fabric_monitor i_mon (.clk(clk), .rstn(rstn), .av_req(av_req), .av_rsp(av_rsp),
	.fab_cfg_in(fab_cfg_in), .hilo_sel(hilo_sel), .fab_out(fab_out), .fab_data(fab_data), .adc_resp(adc_resp),
	.conv_cmd(conv_cmd), .conv_start(conv_start), .switch_en(switch_en));

/* File: tb/adc_core_model.sv */
// Behavioural converter core answering start pulses
`timescale 1ns/1ps
module adc_core_model
	import sar_fabric_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic conv_start,
	input wire logic slow,
	input wire logic [15:0] result_in,
	input wire logic sat_in,
	input wire logic rng_in,
	output adc_resp_t adc_resp
);
	logic [1:0] phase_reg;
	logic [3:0] cnt_reg;
	logic next_reg;
	logic done_reg;
	// Sample then convert; slow mode stretches both phases
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			phase_reg <= 2'h0;
			cnt_reg <= 4'h0;
			next_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			next_reg <= 1'b0;
			done_reg <= 1'b0;
			if (phase_reg == 2'h0 && conv_start) begin
				phase_reg <= 2'h1;
				cnt_reg <= slow ? 4'h6 : 4'h1;
			end else if (phase_reg != 2'h0 && cnt_reg != 4'h0) begin
				cnt_reg <= cnt_reg - 4'h1;
			end else if (phase_reg == 2'h1) begin
				next_reg <= 1'b1;
				phase_reg <= 2'h2;
				cnt_reg <= slow ? 4'h8 : 4'h2;
			end else if (phase_reg == 2'h2) begin
				done_reg <= 1'b1;
				phase_reg <= 2'h0;
			end
		end
	end
	// Outside the done cycle the result lines show the inverse, so a stale capture cannot pass
	assign adc_resp = '{next: next_reg, done: done_reg, result: done_reg ? result_in : ~result_in,
		saturate: done_reg ? sat_in : !sat_in, range_hit: done_reg ? rng_in : !rng_in};
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the fabric-control sequencer
`timescale 1ns/1ps
module tb;
	import sar_fabric_pkg::*;
	logic clk;
	logic rstn;
	av_req_t req;
	av_rsp_t rsp;
	fab_cfg_t cfg;
	logic hilo;
	fab_out_t fo;
	logic [11:0] fdata;
	adc_resp_t resp;
	conv_cmd_t cmd;
	logic start;
	logic [NCH-1:0] sw;
	logic slow;
	logic [15:0] rv;
	logic sat;
	logic rng;
	int miscompares = 0;
	int n_checks = 0;
	sar_fabric_control_port i_dut (.clk(clk), .rstn(rstn), .av_req(req), .av_rsp(rsp), .fab_cfg_in(cfg),
		.hilo_sel(hilo), .fab_out(fo), .fab_data(fdata), .adc_resp(resp), .conv_cmd(cmd), .conv_start(start),
		.switch_en(sw));
	adc_core_model i_core (.clk(clk), .rstn(rstn), .conv_start(start), .slow(slow), .result_in(rv),
		.sat_in(sat), .rng_in(rng), .adc_resp(resp));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic err(input string m);
		$display("[ERR] %0t %s", $time, m);
		miscompares++;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp) err(m);
	endtask
	// One access, entered at a rising edge; request held until waitrequest is seen low, only the watchdog ends a hang
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		req <= '{read: !wr, write: wr, address: a, writedata: d};
		do begin
			@(posedge clk);
		end while (rsp.waitrequest !== 1'b0);
		q = rsp.readdata;
		req <= '0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		cmp(q, e, m);
	endtask
	// Bounded wait for start, sample-done or end-of-scan, seen at a falling edge
	task automatic wait_for(input int w);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while ((w == 0 ? start : w == 1 ? fo.sample_done : fo.eos) !== 1'b1 && n < 60);
		if (n >= 60) err("no strobe");
	endtask
	task automatic conclude();
		$display("checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		logic [3:0] bits;
		logic [7:0] st;
		logic [11:0] lo;
		req = '0;
		cfg = '0;
		hilo = 1'b0;
		slow = 1'b0;
		rv = 16'h0;
		sat = 1'b0;
		rng = 1'b0;
		rstn = 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd(OFS_CTRL, 32'h0, "ctrl reset");
		rd(OFS_STIME, STIME_RST, "stime reset");
		rd(OFS_CHEN, 32'h0, "chen reset");
		rd(8'h80, 32'h0, "unmapped");
		wr(OFS_STIME, 32'h40302010);
		// Every select, both resolutions of the alternate, both paths of the synchronizer
		for (int i = 0; i < 4; i++) begin
			slow <= i[0];
			rv <= 16'h9a5c ^ (16'h1357 * i[15:0]);
			sat <= i[0];
			rng <= i[1];
			cfg <= '{trig: 1'b0, st_sel: i[1:0], average: i[0], resolution: i[1], differential: !i[0]};
			wr(OFS_CTRL, {27'h0, i[0], 1'b1, 1'b0, i == 3, 1'b1});
			cfg.trig <= 1'b1;
			wait_for(0);
			bits = !i[1] ? RES_12 : (i[0] ? RES_10 : RES_8);
			st = 8'(16 * (i + 1));
			cmp(32'(cmd), {16'h0, 2'h0, st, bits, i[0], !i[0]}, "command");
			cmp(32'(sw), 32'h0, "switch enables");
			wait_for(1);
			@(posedge clk);
			cfg <= '{trig: 1'b0, st_sel: ~i[1:0], average: !i[0], resolution: !i[1], differential: i[0]};
			wait_for(2);
			cmp({fo.data_valid, fo.tag_valid, fo.tag}, {2'b11, 2'h0, rng, sat}, "tag flags");
			lo = fdata;
			@(posedge clk);
			hilo <= 1'b1;
			@(negedge clk);
			cmp({fdata[3:0], fdata[7:0], lo[7:0]}, {lo[11:8], rv}, "merged result");
			@(posedge clk);
			hilo <= 1'b0;
			@(posedge clk);
			rd(OFS_STATUS, {23'h0, 1'b1, 3'h0, rng, 3'h0, sat}, "status");
			wr(OFS_STATUS, 32'h1ff);
			rd(OFS_WORK0, {16'h0, rv}, "work0");
			rd(OFS_RES0, {16'h0, rv}, "result0");
		end
		wr(OFS_CTRL, 32'h101);
		wait_for(2);
		cmp(fo.data_valid, 1'b1, "firmware trigger");
		@(posedge clk);
		wr(OFS_CTRL, 32'h05);
		wait_for(0);
		wait_for(0);
		cmp(start, 1'b1, "continuous trigger");
		@(posedge clk);
		wr(OFS_CTRL, 32'h01);
		repeat (30) @(posedge clk);
		// Fresh result so a stale output from the fabric runs cannot pass
		rv <= 16'h5ac3;
		// Register mode: output enable on, then off while end-of-scan still fires
		wr(OFS_CHEN, 32'h1);
		wr(OFS_CFG0, 32'h80000000);
		wr(OFS_CTRL, 32'h100);
		wait_for(2);
		cmp({fo.data_valid, fdata}, {1'b1, rv[11:0]}, "enabled output");
		@(posedge clk);
		wr(OFS_CFG0, 32'h0);
		wr(OFS_CTRL, 32'h100);
		wait_for(2);
		cmp(fo.data_valid, 1'b0, "disabled output");
		conclude();
	end
	initial begin
		#1000000;
		err("timeout");
		conclude();
	end
endmodule
